// *** src/ipp_param_set.sv ***
// Parameter set of the iris loop compensator, with AXI4-Lite slave.
// Assumes err_i is synchronous to sys_clk_i and holds the filtered error.
//
// Design decision made here: the AXI4-Lite register port.
`default_nettype none
module ipp_param_set (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic signed [25:0] err_i,
   output logic [11:0] gain_o,
   output logic signed [25:0] int_err_o,
   output logic signed [25:0] dif_err_o,
   output logic [6:0] zero_a_hz_o,
   output logic [6:0] zero_b_hz_o,
   output logic [10:0] pole_hz_o,
   output logic upd_o
);
   localparam int EW = ipp_pkg::ERR_W;
   // ***************************************************
   // Helpers
   // ***************************************************
   // Address decode: bit 6 marks a mapped, aligned word
   function automatic logic [6:0] decode(input logic [7:0] a);
      logic [5:0] idx;
      idx = a[7:2];
      decode = {1'b0, idx};
      if (a[1:0] == 2'h0 && (idx == ipp_pkg::IDX_GAIN ||
          idx == ipp_pkg::IDX_SHAPE || idx == ipp_pkg::IDX_STAT)) begin
         decode = {1'b1, idx};
      end
   endfunction
   // Byte-lane merge into a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
      merge = old;
      if (s[0]) merge[7:0] = d[7:0];
      if (s[1]) merge[15:8] = d[15:8];
   endfunction
   // Linear gain in 1/64 units: 0.125 * 2^(e-3) * (16+m)
   function automatic logic [11:0] gain_lin(input logic [6:0] c);
      gain_lin = 12'h000; // Code zero is zero gain
      if (c != 7'h00) gain_lin = 12'({7'h00, 1'b1, c[3:0]} << c[6:4]);
   endfunction
   // Dead band: code n ignores magnitudes below 2^(n-1) fraction steps
   function automatic logic signed [25:0] deadband(
      input logic signed [25:0] x, input logic [3:0] lvl);
      logic [25:0] mag;
      logic [25:0] thr;
      mag = x[EW-1] ? 26'(-x) : 26'(x);
      // Code zero gives no threshold, so nothing is removed
      thr = (lvl == 4'h0) ? 26'h0000000 : 26'h0000001 << (lvl - 4'h1);
      // Code 15 gives one full step, i.e. 2^14 fraction steps
      deadband = (mag < thr) ? 26'sh0000000 : x;
   endfunction
   // ***************************************************
   // Register write channel
   // ***************************************************
   logic aw_held_r, aw_held_nxt;     // Address taken, waiting
   logic [7:0] aw_addr_r, aw_addr_nxt;
   logic w_held_r, w_held_nxt;       // Data taken, waiting
   logic [31:0] w_data_r, w_data_nxt;
   logic [3:0] w_strb_r, w_strb_nxt;
   logic awready_r, awready_nxt;
   logic wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic [15:0] gain_reg_r, gain_reg_nxt;   // Offset 01h word
   logic [15:0] shape_reg_r, shape_reg_nxt; // Offset 02h word
   logic wr_go;
   logic [6:0] aw_dec;
   assign aw_dec = decode(aw_addr_r);
   assign wr_go = aw_held_r && w_held_r && !bvalid_r;
   // Address and data are taken in either order, then committed
   always_comb begin
      aw_held_nxt = aw_held_r;
      aw_addr_nxt = aw_addr_r;
      w_held_nxt = w_held_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      awready_nxt = awready_r;
      wready_nxt = wready_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      gain_reg_nxt = gain_reg_r;
      shape_reg_nxt = shape_reg_r;
      if (s_axi_awvalid_i && awready_r) begin
         aw_held_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr_i;
         awready_nxt = 1'b0;
      end
      if (s_axi_wvalid_i && wready_r) begin
         w_held_nxt = 1'b1;
         w_data_nxt = s_axi_wdata_i;
         w_strb_nxt = s_axi_wstrb_i;
         wready_nxt = 1'b0;
      end
      if (wr_go) begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = ipp_pkg::RESP_OKAY;
         if (aw_dec == {1'b1, ipp_pkg::IDX_GAIN}) begin
            // Gain code lands in the top seven bits
            gain_reg_nxt = merge(gain_reg_r, w_data_r, w_strb_r);
         end else if (aw_dec == {1'b1, ipp_pkg::IDX_SHAPE}) begin
            // Zero, pole and both dead bands
            shape_reg_nxt = merge(shape_reg_r, w_data_r, w_strb_r);
         end else begin
            // Unmapped or read-only word: refused, nothing stored
            bresp_nxt = ipp_pkg::RESP_SLVERR;
         end
      end
      // Ready again only once the response is accepted
      if (bvalid_r && s_axi_bready_i) begin
         bvalid_nxt = 1'b0;
         awready_nxt = 1'b1;
         wready_nxt = 1'b1;
      end
   end
   // Registers reset to zero, except awready_r and wready_r, which reset to one
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_held_r <= 1'b0;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
         gain_reg_r <= ipp_pkg::REG_RST;
         shape_reg_r <= ipp_pkg::REG_RST;
      end else begin
         aw_held_r <= aw_held_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_held_r <= w_held_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         gain_reg_r <= gain_reg_nxt;
         shape_reg_r <= shape_reg_nxt;
      end
   end
   // Field views
   logic [6:0] gain_code;
   logic [3:0] idb_lvl, ddb_lvl, zero_sel, pole_sel;
   assign gain_code = gain_reg_r[ipp_pkg::GAIN_LSB +: ipp_pkg::GAIN_W];
   assign idb_lvl = shape_reg_r[ipp_pkg::IDB_LSB +: ipp_pkg::SEL_W];
   assign ddb_lvl = shape_reg_r[ipp_pkg::DDB_LSB +: ipp_pkg::SEL_W];
   assign zero_sel = shape_reg_r[ipp_pkg::ZERO_LSB +: ipp_pkg::SEL_W];
   assign pole_sel = shape_reg_r[ipp_pkg::POLE_LSB +: ipp_pkg::SEL_W];
   // ***************************************************
   // Register read channel
   // ***************************************************
   logic arready_r, arready_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [15:0] upd_cnt_r; // Updates issued, wraps
   logic [6:0] ar_dec;
   assign ar_dec = decode(s_axi_araddr_i);
   // One read outstanding; answer one cycle after the address
   always_comb begin
      arready_nxt = arready_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_arvalid_i && arready_r) begin
         arready_nxt = 1'b0;
         rvalid_nxt = 1'b1;
         rresp_nxt = ar_dec[6] ? ipp_pkg::RESP_OKAY : ipp_pkg::RESP_SLVERR;
         case (ar_dec)
            {1'b1, ipp_pkg::IDX_GAIN}: rdata_nxt = {16'h0000, gain_reg_r};
            {1'b1, ipp_pkg::IDX_SHAPE}: rdata_nxt = {16'h0000, shape_reg_r};
            {1'b1, ipp_pkg::IDX_STAT}: rdata_nxt = {16'h0000, upd_cnt_r};
            default: rdata_nxt = 32'h00000000;
         endcase
      end
      if (rvalid_r && s_axi_rready_i) begin
         rvalid_nxt = 1'b0;
         arready_nxt = 1'b1;
      end
   end
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= 2'h0;
      end else begin
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end
   // ***************************************************
   // Compensator update pipeline
   // ***************************************************
   logic [9:0] div_r, div_nxt;        // Update rate divider
   logic tick_r, tick_nxt;            // One-cycle update enable
   logic [1:0] pipe_r, pipe_nxt;      // Waits out the table read
   logic [11:0] stg_gain_r, stg_gain_nxt;
   logic signed [25:0] stg_int_r, stg_int_nxt;
   logic signed [25:0] stg_dif_r, stg_dif_nxt;
   logic [3:0] act_zero_r, act_zero_nxt, act_pole_r, act_pole_nxt;
   logic [11:0] gain_r, gain_nxt;
   logic signed [25:0] int_r, int_nxt, dif_r, dif_nxt;
   logic [6:0] za_r, za_nxt, zb_r, zb_nxt, rom_za, rom_zb;
   logic [10:0] pole_r, pole_nxt, rom_pole;
   logic upd_r, upd_nxt;
   logic [15:0] upd_cnt_nxt;
   // Sample fields at the tick, publish all outputs together later.
   // Staging keeps gain and frequencies from one and the same update.
   always_comb begin
      div_nxt = (div_r == ipp_pkg::CNT_LAST) ? 10'h000 : div_r + 10'h001;
      tick_nxt = (div_r == ipp_pkg::CNT_LAST);
      pipe_nxt = {pipe_r[0], tick_r};
      stg_gain_nxt = stg_gain_r;
      stg_int_nxt = stg_int_r;
      stg_dif_nxt = stg_dif_r;
      act_zero_nxt = act_zero_r;
      act_pole_nxt = act_pole_r;
      gain_nxt = gain_r;
      int_nxt = int_r;
      dif_nxt = dif_r;
      za_nxt = za_r;
      zb_nxt = zb_r;
      pole_nxt = pole_r;
      upd_nxt = 1'b0;
      upd_cnt_nxt = upd_cnt_r;
      if (tick_r) begin
         // Fields as they stand now apply to this update
         stg_gain_nxt = gain_lin(gain_code);
         stg_int_nxt = deadband(err_i, idb_lvl);
         stg_dif_nxt = deadband(err_i, ddb_lvl);
         act_zero_nxt = zero_sel;
         act_pole_nxt = pole_sel;
      end
      if (pipe_r[1]) begin
         gain_nxt = stg_gain_r;
         int_nxt = stg_int_r;
         dif_nxt = stg_dif_r;
         za_nxt = rom_za;
         zb_nxt = rom_zb;
         pole_nxt = rom_pole;
         upd_nxt = 1'b1;
         upd_cnt_nxt = upd_cnt_r + 16'h0001;
      end
   end
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_r <= 10'h000;
         tick_r <= 1'b0;
         pipe_r <= 2'h0;
         stg_gain_r <= 12'h000;
         stg_int_r <= 26'sh0000000;
         stg_dif_r <= 26'sh0000000;
         act_zero_r <= 4'h0;
         act_pole_r <= 4'h0;
         gain_r <= 12'h000;
         int_r <= 26'sh0000000;
         dif_r <= 26'sh0000000;
         za_r <= 7'h00;
         zb_r <= 7'h00;
         pole_r <= 11'h000;
         upd_r <= 1'b0;
         upd_cnt_r <= 16'h0000;
      end else begin
         div_r <= div_nxt;
         tick_r <= tick_nxt;
         pipe_r <= pipe_nxt;
         stg_gain_r <= stg_gain_nxt;
         stg_int_r <= stg_int_nxt;
         stg_dif_r <= stg_dif_nxt;
         act_zero_r <= act_zero_nxt;
         act_pole_r <= act_pole_nxt;
         gain_r <= gain_nxt;
         int_r <= int_nxt;
         dif_r <= dif_nxt;
         za_r <= za_nxt;
         zb_r <= zb_nxt;
         pole_r <= pole_nxt;
         upd_r <= upd_nxt;
         upd_cnt_r <= upd_cnt_nxt;
      end
   end
   // Frequency tables, read from the sampled selects
   ipp_freq_rom u_rom (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .zero_sel_i(act_zero_r),
      .pole_sel_i(act_pole_r),
      .zero_a_o(rom_za),
      .zero_b_o(rom_zb),
      .pole_o(rom_pole)
   );
   // Outputs, all straight from flip-flops
   assign s_axi_awready_o = awready_r;
   assign s_axi_wready_o = wready_r;
   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_bresp_o = bresp_r;
   assign s_axi_arready_o = arready_r;
   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rdata_o = rdata_r;
   assign s_axi_rresp_o = rresp_r;
   assign gain_o = gain_r;
   assign int_err_o = int_r;
   assign dif_err_o = dif_r;
   assign zero_a_hz_o = za_r;
   assign zero_b_hz_o = zb_r;
   assign pole_hz_o = pole_r;
   assign upd_o = upd_r;
   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   property p_gain_wr;
      wr_go && aw_dec == {1'b1, ipp_pkg::IDX_GAIN} && w_strb_r[1]
         |=> gain_code == $past(w_data_r[15:9]);
   endproperty
   a_gain_wr: assert property (p_gain_wr)
      else $error("gain code not stored from write");
   property p_gain_zero;
      tick_r && gain_code == 7'h00 |-> ##3 gain_o == 12'h000;
   endproperty
   a_gain_zero: assert property (p_gain_zero)
      else $error("gain code zero not zero gain");
   property p_gain_max;
      tick_r && gain_code == 7'h7F |-> ##3 gain_o == 12'hF80;
   endproperty
   a_gain_max: assert property (p_gain_max)
      else $error("top gain code not 62");
   property p_int_off;
      tick_r && idb_lvl == 4'h0 |-> ##3 int_err_o == $past(err_i, 3);
   endproperty
   a_int_off: assert property (p_int_off)
      else $error("integrator band altered error while off");
   property p_dif_band;
      tick_r && ddb_lvl == 4'h3 && err_i < 26'sh0000004 &&
         err_i > -26'sh0000004 |-> ##3 dif_err_o == 26'sh0000000;
   endproperty
   a_dif_band: assert property (p_dif_band)
      else $error("differentiator band passed small error");
   property p_full_band;
      tick_r && idb_lvl == 4'hF && err_i < 26'sh0004000 &&
         err_i > -26'sh0004000 |-> ##3 int_err_o == 26'sh0000000;
   endproperty
   a_full_band: assert property (p_full_band)
      else $error("sub-step error passed at top band code");
   property p_zero_pair;
      upd_o && act_zero_r == 4'h5 |-> zero_a_hz_o == 7'h23 &&
         zero_b_hz_o == 7'h1E;
   endproperty
   a_zero_pair: assert property (p_zero_pair)
      else $error("zero pair wrong for code 5");
   property p_pole_top;
      upd_o && act_pole_r == 4'hF |-> pole_hz_o == 11'h7A8;
   endproperty
   a_pole_top: assert property (p_pole_top)
      else $error("pole wrong for code 15");
   property p_upd_seq;
      tick_r |-> !upd_o ##3 upd_o;
   endproperty
   a_upd_seq: assert property (p_upd_seq)
      else $error("update not published three cycles after tick");
   property p_hold;
      !pipe_r[1] |=> $stable(gain_o) && $stable(pole_hz_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("outputs changed outside an update");
   property p_b_hold;
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o &&
         $stable(s_axi_bresp_o);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped before accept");
   c_gain_wr: cover property (wr_go && aw_dec[6]);
   c_band: cover property (tick_r && idb_lvl != 4'h0);
   c_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule // ipp_param_set
`default_nettype wire

// *** common/ipp_pkg.sv ***
// Constants for the iris compensator parameter block.
// Assumes a 20 MHz system clock and an AXI4-Lite register bus.
`default_nettype none
package ipp_pkg;
   // ***************************************************
   // Timing
   // ***************************************************
   localparam int unsigned CLK_HZ = 20_000_000; // System clock rate
   localparam int unsigned UPD_HZ = 31_250;     // Compensator update rate
   localparam int unsigned UPD_CYC = CLK_HZ / UPD_HZ; // Cycles per update
   localparam int CNT_W = 10;                   // Divider width
   localparam logic [9:0] CNT_LAST = 10'(UPD_CYC - 1);
   // ***************************************************
   // Register map: index, byte address is four times it
   // ***************************************************
   localparam logic [5:0] IDX_GAIN = 6'h01;  // Gain code, bits 15..9
   localparam logic [5:0] IDX_SHAPE = 6'h02; // Zero, pole, dead bands
   localparam logic [5:0] IDX_STAT = 6'h08;  // Update counter, read only
   localparam int ADDR_W = 8;                // Byte address width
   localparam int REG_W = 16;                // Stored register width
   localparam logic [15:0] REG_RST = 16'h0000;
   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int GAIN_LSB = 9;   // Gain code in bits 15..9
   localparam int GAIN_W = 7;
   localparam int IDB_LSB = 0;    // Integrator dead band
   localparam int DDB_LSB = 4;    // Differentiator dead band
   localparam int ZERO_LSB = 8;   // Zero select
   localparam int POLE_LSB = 12;  // Pole select
   localparam int SEL_W = 4;
   // ***************************************************
   // Data path
   // ***************************************************
   localparam int ERR_W = 26;     // Error word, signed
   localparam int FRAC_W = 14;    // Bits below one converter step
   localparam int GAIN_OUT_W = 12; // Linear gain, units of 1/64
   localparam int HZ_W = 11;       // Frequency in hertz
   localparam int ZHZ_W = 7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// *** src/ipp_freq_rom.sv ***
// Zero and pole frequency tables of the compensator.
// Assumes the select codes are held stable for a cycle before use.
`default_nettype none
module ipp_freq_rom (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [3:0] zero_sel_i,
   input wire logic [3:0] pole_sel_i,
   output logic [6:0] zero_a_o,
   output logic [6:0] zero_b_o,
   output logic [10:0] pole_o
);
   logic [13:0] zero_nxt; // Paired zero frequencies
   logic [10:0] pole_nxt; // Pole frequency
   // ***************************************************
   // Table lookup
   // ***************************************************
   always_comb begin
      case (zero_sel_i)
         4'h0: zero_nxt = {7'h0A, 7'h0A};
         4'h1: zero_nxt = {7'h0F, 7'h0F};
         4'h2: zero_nxt = {7'h14, 7'h14};
         4'h3: zero_nxt = {7'h19, 7'h19};
         4'h4: zero_nxt = {7'h1E, 7'h1E};
         4'h5: zero_nxt = {7'h23, 7'h1E}; // Unequal pair
         4'h6: zero_nxt = {7'h23, 7'h23};
         4'h7: zero_nxt = {7'h28, 7'h23}; // Unequal pair
         4'h8: zero_nxt = {7'h28, 7'h28};
         4'h9: zero_nxt = {7'h2D, 7'h2D};
         4'hA: zero_nxt = {7'h32, 7'h32};
         4'hB: zero_nxt = {7'h37, 7'h37};
         4'hC: zero_nxt = {7'h3C, 7'h3C};
         4'hD: zero_nxt = {7'h41, 7'h41};
         4'hE: zero_nxt = {7'h46, 7'h46};
         default: zero_nxt = {7'h4B, 7'h4B};
      endcase
      case (pole_sel_i)
         4'h0: pole_nxt = 11'h2C6;
         4'h1: pole_nxt = 11'h316;
         4'h2: pole_nxt = 11'h366;
         4'h3: pole_nxt = 11'h3B6;
         4'h4: pole_nxt = 11'h410;
         4'h5: pole_nxt = 11'h460;
         4'h6: pole_nxt = 11'h4B0;
         4'h7: pole_nxt = 11'h500;
         4'h8: pole_nxt = 11'h55A;
         4'h9: pole_nxt = 11'h5AA;
         4'hA: pole_nxt = 11'h5FA;
         4'hB: pole_nxt = 11'h654;
         4'hC: pole_nxt = 11'h6A4;
         4'hD: pole_nxt = 11'h6FE;
         4'hE: pole_nxt = 11'h74E;
         default: pole_nxt = 11'h7A8;
      endcase
   end
   // Registered read data
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         zero_a_o <= 7'h00;
         zero_b_o <= 7'h00;
         pole_o <= 11'h000;
      end else begin
         zero_a_o <= zero_nxt[13:7];
         zero_b_o <= zero_nxt[6:0];
         pole_o <= pole_nxt;
      end
   end
endmodule // ipp_freq_rom
`default_nettype wire

// *** tb/test_iris_pid_parameter_set.sv ***
// Self-checking bench for the iris compensator parameter set.
// Assumes ipp_param_set with AXI4-Lite slave and 640-cycle update tick.
`default_nettype none
module test_iris_pid_parameter_set;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************
   // Stimulus signals and expectation queues
   // ****************************************************
   logic clk = 1'b0; // 20 MHz system clock
   logic rst = 1'b1; // Reset, active high
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h0;
   logic signed [25:0] err = 26'sh0; // Filtered error input
   logic awready, wready, bvalid, arready, rvalid, upd;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [11:0] gain;
   logic signed [25:0] ierr, derr;
   logic [6:0] za, zb;
   logic [10:0] pole;
   logic [1:0] bq[$];      // Expected write responses
   logic [33:0] rq[$];     // Expected read response and data
   logic [88:0] uq[$];     // Expected update outputs
   logic [33:0] rx;
   int bad_count = 0, cmp_count = 0, seed, i, j;
   logic [6:0] g;
   logic signed [25:0] e;
   // Frequency tables of the zero pairs and the pole
   int zat[16] = '{10,15,20,25,30,35,35,40,40,45,50,55,60,65,70,75};
   int zbt[16] = '{10,15,20,25,30,30,35,35,40,45,50,55,60,65,70,75};
   int plt[16] = '{710,790,870,950,1040,1120,1200,1280,1370,1450,1530,
      1620,1700,1790,1870,1960};
   always #25 clk = ~clk;
   ipp_param_set u_ipp_param_set (.sys_clk_i(clk), .rst_i(rst),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .err_i(err), .gain_o(gain),
      .int_err_o(ierr), .dif_err_o(derr), .zero_a_hz_o(za),
      .zero_b_hz_o(zb), .pole_hz_o(pole), .upd_o(upd));
   // ****************************************************
   // Compare tasks and reference functions
   // ****************************************************
   task automatic chk(string nm, logic [31:0] x, logic [31:0] s);
      cmp_count++;
      if (x !== s) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic chk_u(logic [88:0] x);
      chk("gain", x[88:77], gain);
      chk("int_err", x[76:51], ierr[25:0]);
      chk("dif_err", x[50:25], derr[25:0]);
      chk("zero_a", x[24:18], za);
      chk("zero_b", x[17:11], zb);
      chk("pole", x[10:0], pole);
   endtask
   // Dead band: strictly below the threshold reads as zero
   function automatic logic [25:0] db(logic signed [25:0] x, int b);
      logic signed [25:0] m;
      m = (x < 0) ? -x : x;
      return (b != 0 && m < (1 << (b - 1))) ? 26'h0 : x;
   endfunction
   // ****************************************************
   // Bus master tasks, one transfer in flight
   // ****************************************************
   task automatic wr(logic [7:0] a, logic [15:0] d, logic [3:0] s,
      logic [1:0] r);
      bq.push_back(r);
      awaddr <= a; wdata <= {16'h0000, d}; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      // No cycle count assumed: only the watchdog ends a hung wait
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] d, logic [1:0] r);
      rq.push_back({r, d});
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      @(posedge clk);
   endtask
   // Wait for one update pulse, then one more edge.
   // Unbounded on purpose, so a missing update ends in the watchdog.
   task automatic wu;
      do @(posedge clk); while (!upd);
      @(posedge clk);
   endtask
   // Monitor: takes the oldest note whenever a result appears
   always @(posedge clk) begin
      if (bvalid && bready) chk("bresp", 32'(bq.pop_front()), 32'(bresp));
      if (rvalid && rready) begin
         rx = rq.pop_front();
         chk("rresp", 32'(rx[33:32]), 32'(rresp));
         chk("rdata", rx[31:0], rdata);
      end
      if (upd && uq.size() > 0) chk_u(uq.pop_front());
   end
   // ****************************************************
   // Verdict and watchdog
   // ****************************************************
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Seventeen steps of two updates, about 1300 cycles each, fit well inside this
   initial begin
      #3_000_000;
      bad_count++;
      $display("watchdog expired");
      results;
   end
   initial begin
      seed = $urandom(32'h376EDBC9);
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(8'h04, 32'h0, 2'h0);
      rd(8'h08, 32'h0, 2'h0);
      rd(8'h20, 32'h0, 2'h0);
      rd(8'h0C, 32'h0, 2'h2);
      rd(8'h05, 32'h0, 2'h2);
      wr(8'h20, 16'h5555, 4'h3, 2'h2);
      wr(8'h04, 16'hABCD, 4'h1, 2'h0);
      wr(8'h04, 16'h1234, 4'h2, 2'h0);
      rd(8'h04, 32'h0000_12CD, 2'h0);
      $display("register access test done");
      // Sweep every select and band code, both ends of the gain code
      for (i = 0; i < 16; i++) begin
         j = 15 - i;
         g = (i == 0) ? 7'h00 : (i == 15) ? 7'h7F : 7'($urandom);
         e = (i == 0) ? 26'sd5 : 26'sd1 <<< (i - 1);
         e = e - 26'($urandom % 2);
         if ($urandom % 2) e = -e;
         wr(8'h04, {g, 9'h000}, 4'h3, 2'h0);
         wr(8'h08, {4'(i), 4'(i), 4'(j), 4'(i)}, 4'h3, 2'h0);
         rd(8'h08, {16'h0, 4'(i), 4'(i), 4'(j), 4'(i)}, 2'h0);
         err <= e;
         wu;
         uq.push_back({(g == 0) ? 12'h000 : 12'((16 + g[3:0]) << g[6:4]),
            db(e, i), db(e, j), 7'(zat[i]), 7'(zbt[i]),
            11'(plt[i])});
         wu;
      end
      $display("compensator sweep test done");
      // Sub-step error against integrator code 15, differentiator code 3
      e = 26'sd3 - 26'($urandom % 7);
      wr(8'h08, 16'h003F, 4'h3, 2'h0);
      err <= e;
      wu;
      uq.push_back({12'((16 + g[3:0]) << g[6:4]), db(e, 15), db(e, 3),
         7'(zat[0]), 7'(zbt[0]), 11'(plt[0])});
      wu;
      $display("small error band test done");
      results;
   end
endmodule // test_iris_pid_parameter_set
`default_nettype wire
